// *** logic/hcid_cfg.svh ***
// Constants for the hub configuration image decoder.
//------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------
// Overview of operation
// - Fetch image after reset, apply before operating.
// - Bytes 0-5: vendor, product, release, high first.
// - Bytes 6-8 options; 9-11 power, current, timing.
// - Option three bit 7: bus powered.
// - Option three bit 6: port indicators enabled.
// - Option three bit 5: full speed only.
// - Option three bit 4: one translator per port.
// - Option three bit 3: suppress EOP at EOF1.
// - Option three bit 2: ganged over-current sensing.
// - Option three bit 1: ganged power switching.
// - Option three bit 0: compound device.
// - Option two bits 7:4: non-removable ports.
// - Option two bits 3:0: inactive ports.
// - Option one bit 7: dynamic power switching.
// - Option one bit 6: OTG host support.
// - Option one bits 3:0: filter 2/4/6 ms.
// - Byte 9: upstream current, 2 mA units.
// - Byte 10: controller current, 2 mA units.
// - Byte 11: power good delay, 2 ms units.
// - Filtered over-current reports and cuts port power.
// - Slave strap skips memory, accepts written bytes.
`ifndef HCID_CFG_SVH
`define HCID_CFG_SVH

//------------------------------------------------------------
// Image layout
//------------------------------------------------------------
`define HCID_IMG_BYTES 12
`define HCID_IDX_LAST 4'hB
`define HCID_IDX_VEND_HI 4'h0
`define HCID_IDX_VEND_LO 4'h1
`define HCID_IDX_PROD_HI 4'h2
`define HCID_IDX_PROD_LO 4'h3
`define HCID_IDX_REL_HI 4'h4
`define HCID_IDX_REL_LO 4'h5
`define HCID_IDX_OPT3 4'h6
`define HCID_IDX_OPT2 4'h7
`define HCID_IDX_OPT1 4'h8
`define HCID_IDX_BUDGET 4'h9
`define HCID_IDX_CURRENT 4'hA
`define HCID_IDX_PGOOD 4'hB
`define HCID_BYTE_RESET 8'h00

//------------------------------------------------------------
// Option bit positions
//------------------------------------------------------------
`define HCID_O3_BUS_PWR 7
`define HCID_O3_INDIC 6
`define HCID_O3_FS_ONLY 5
`define HCID_O3_MULTI_TT 4
`define HCID_O3_EOP_DIS 3
`define HCID_O3_OC_GANG 2
`define HCID_O3_PWR_GANG 1
`define HCID_O3_COMPOUND 0
`define HCID_O2_NONREM 7:4
`define HCID_O2_INACT 3:0
`define HCID_O1_DYN_PWR 7
`define HCID_O1_OTG 6
`define HCID_O1_OC_TMR 3:0

//------------------------------------------------------------
// Filter timing
//------------------------------------------------------------
`define HCID_OC_CODE_2MS 4'h5
`define HCID_OC_CODE_4MS 4'hA
`define HCID_OC_CODE_6MS 4'hF
`define HCID_OC_STEP_NS 2000000
`define HCID_CLK_NS 20
`define HCID_STRAP_WAIT 2'h3

`endif

// *** logic/hcid_pkg.sv ***
// Types shared by the hub configuration image decoder.
package hcid_pkg;

    typedef logic [7:0] hcid_byte_t;

    typedef enum {
        ST_STRAP_WAIT,
        ST_EE_REQ,
        ST_EE_WAIT,
        ST_SLAVE,
        ST_APPLY,
        ST_RUN
    } hcid_state_e;

    typedef struct packed {
        logic [15:0] vendor_code;
        logic [15:0] product_code;
        logic [15:0] release_code;
        logic bus_powered;
        logic indicators_en;
        logic full_speed_only;
        logic multi_tt;
        logic eop_disable;
        logic oc_ganged;
        logic pwr_ganged;
        logic compound;
        logic [3:0] non_removable;
        logic [3:0] port_inactive;
        logic dyn_power;
        logic otg_en;
        logic [3:0] oc_timer_code;
        logic [7:0] power_budget;
        logic [7:0] controller_current_need;
        logic [7:0] power_good_delay;
    } hcid_opts_s;

endpackage

// *** logic/hcid_top.sv ***
// Hub configuration image loader, decoder and over-current filter.
`timescale 1ns/1ps
`include "hcid_cfg.svh"

module hcid_top import hcid_pkg::*; #(
    parameter int OC_STEP_CYC = (`HCID_OC_STEP_NS + `HCID_CLK_NS - 1) / `HCID_CLK_NS
) (
    // Clock, reset and enable.
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // Strap pin, low selects the serial slave path.
    input wire logic serial_slave_select_n_in,
    // Serial memory byte reader.
    output logic ee_req_out,
    output logic [3:0] ee_addr_out,
    input wire logic ee_ack_in,
    input wire logic ee_absent_in,
    input wire logic [7:0] ee_data_in,
    // Serial slave byte port.
    input wire logic slv_wr_in,
    input wire logic slv_rd_in,
    input wire logic [3:0] slv_addr_in,
    input wire logic [7:0] slv_wdata_in,
    input wire logic slv_done_in,
    output logic [7:0] slv_rdata_out,
    // Port control.
    input wire logic [3:0] port_power_req_in,
    input wire logic [3:0] overcurrent_sense_n_in,
    output logic [3:0] port_power_switch_n_out,
    output logic [3:0] oc_report_out,
    // Decoded configuration.
    output logic cfg_valid_out,
    output hcid_opts_s opts_out
);

    //------------------------------------------------------------
    // Storage and helpers
    //------------------------------------------------------------
    hcid_byte_t img_reg [`HCID_IMG_BYTES];
    hcid_state_e state_reg;
    logic [1:0] strap_wait_reg;
    logic [3:0] idx_reg;
    logic slave_mode_reg;
    logic [1:0] strap_sync_reg;
    logic [3:0] ocs_meta_reg;
    logic [3:0] ocs_sync_reg;
    logic [19:0] oc_limit_reg;
    logic [19:0] oc_cnt_reg [4];
    logic [3:0] oc_trip_reg;
    logic [3:0] oc_sense;
    logic [3:0] port_on;
    logic trip_any;

    // Maps a timer code to its number of 2 ms steps; reserved codes fall
    // back to the shortest delay so a misprogrammed part still filters.
    function automatic logic [1:0] oc_steps(input logic [3:0] code);
        case (code)
            `HCID_OC_CODE_4MS: oc_steps = 2'h2;
            `HCID_OC_CODE_6MS: oc_steps = 2'h3;
            default: oc_steps = 2'h1;
        endcase
    endfunction

    // Index check shared by the slave write and read paths.
    function automatic logic idx_ok(input logic [3:0] idx);
        idx_ok = (idx <= `HCID_IDX_LAST);
    endfunction

    //------------------------------------------------------------
    // Pin synchronisers
    //------------------------------------------------------------
    // Strap and sense pins are asynchronous to the core clock.
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            strap_sync_reg <= 2'h3;
            ocs_meta_reg <= 4'hF;
            ocs_sync_reg <= 4'hF;
        end else if (ce_in) begin
            strap_sync_reg <= {strap_sync_reg[0], serial_slave_select_n_in};
            ocs_meta_reg <= overcurrent_sense_n_in;
            ocs_sync_reg <= ocs_meta_reg;
        end
    end

    //------------------------------------------------------------
    // Load sequencer
    //------------------------------------------------------------
    // The strap is sampled only after the synchroniser has filled, so the
    // choice of path is never taken from a reset value.
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_reg <= ST_STRAP_WAIT;
            strap_wait_reg <= 2'h0;
            idx_reg <= 4'h0;
            slave_mode_reg <= 1'b0;
        end else if (ce_in) begin
            case (state_reg)
                ST_STRAP_WAIT: begin
                    strap_wait_reg <= strap_wait_reg + 2'h1;
                    if (strap_wait_reg == `HCID_STRAP_WAIT) begin
                        slave_mode_reg <= !strap_sync_reg[1];
                        state_reg <= strap_sync_reg[1] ? ST_EE_REQ : ST_SLAVE;
                    end
                end
                ST_EE_REQ: begin
                    state_reg <= ST_EE_WAIT;
                end
                ST_EE_WAIT: begin
                    if (ee_absent_in) begin
                        state_reg <= ST_APPLY;
                    end else if (ee_ack_in) begin
                        if (idx_reg == `HCID_IDX_LAST) begin
                            state_reg <= ST_APPLY;
                        end else begin
                            idx_reg <= idx_reg + 4'h1;
                            state_reg <= ST_EE_REQ;
                        end
                    end
                end
                ST_SLAVE: begin
                    if (slv_done_in) begin
                        state_reg <= ST_APPLY;
                    end
                end
                ST_APPLY: begin
                    state_reg <= ST_RUN;
                end
                ST_RUN: begin
                    state_reg <= ST_RUN;
                end
                default: begin
                    state_reg <= ST_STRAP_WAIT;
                end
            endcase
        end
    end

    // Memory request is a level that stands until the reader answers.
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ee_req_out <= 1'b0;
            ee_addr_out <= 4'h0;
        end else if (ce_in) begin
            if (state_reg == ST_EE_REQ) begin
                ee_req_out <= 1'b1;
                ee_addr_out <= idx_reg;
            end else if (state_reg == ST_EE_WAIT && (ee_ack_in || ee_absent_in)) begin
                ee_req_out <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------
    // Image bytes
    //------------------------------------------------------------
    // An absent memory leaves the all-zero image, a neutral default.
    // Slave writes are refused once the image has been applied.
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < `HCID_IMG_BYTES; i++) begin
                img_reg[i] <= `HCID_BYTE_RESET;
            end
        end else if (ce_in) begin
            if (state_reg == ST_EE_WAIT && ee_ack_in && !ee_absent_in) begin
                img_reg[idx_reg] <= ee_data_in;
            end else if (state_reg == ST_SLAVE && slv_wr_in && idx_ok(slv_addr_in)) begin
                img_reg[slv_addr_in] <= slv_wdata_in;
            end
        end
    end

    // Read-back of the image; unmapped indexes read as zero.
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            slv_rdata_out <= `HCID_BYTE_RESET;
        end else if (ce_in && slv_rd_in && slave_mode_reg) begin
            slv_rdata_out <= idx_ok(slv_addr_in) ? img_reg[slv_addr_in] : `HCID_BYTE_RESET;
        end
    end

    //------------------------------------------------------------
    // Decode and apply
    //------------------------------------------------------------
    // Options are copied once, so the hub never sees a half-loaded image.
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            opts_out <= '0;
            cfg_valid_out <= 1'b0;
            oc_limit_reg <= 20'h0;
        end else if (ce_in && state_reg == ST_APPLY) begin
            cfg_valid_out <= 1'b1;
            opts_out.vendor_code <= {img_reg[`HCID_IDX_VEND_HI], img_reg[`HCID_IDX_VEND_LO]};
            opts_out.product_code <= {img_reg[`HCID_IDX_PROD_HI], img_reg[`HCID_IDX_PROD_LO]};
            opts_out.release_code <= {img_reg[`HCID_IDX_REL_HI], img_reg[`HCID_IDX_REL_LO]};
            opts_out.bus_powered <= img_reg[`HCID_IDX_OPT3][`HCID_O3_BUS_PWR];
            opts_out.indicators_en <= img_reg[`HCID_IDX_OPT3][`HCID_O3_INDIC];
            opts_out.full_speed_only <= img_reg[`HCID_IDX_OPT3][`HCID_O3_FS_ONLY];
            opts_out.multi_tt <= img_reg[`HCID_IDX_OPT3][`HCID_O3_MULTI_TT];
            opts_out.eop_disable <= img_reg[`HCID_IDX_OPT3][`HCID_O3_EOP_DIS];
            opts_out.oc_ganged <= img_reg[`HCID_IDX_OPT3][`HCID_O3_OC_GANG];
            opts_out.pwr_ganged <= img_reg[`HCID_IDX_OPT3][`HCID_O3_PWR_GANG];
            opts_out.compound <= img_reg[`HCID_IDX_OPT3][`HCID_O3_COMPOUND];
            opts_out.non_removable <= img_reg[`HCID_IDX_OPT2][`HCID_O2_NONREM];
            opts_out.port_inactive <= img_reg[`HCID_IDX_OPT2][`HCID_O2_INACT];
            opts_out.dyn_power <= img_reg[`HCID_IDX_OPT1][`HCID_O1_DYN_PWR];
            opts_out.otg_en <= img_reg[`HCID_IDX_OPT1][`HCID_O1_OTG];
            // Bits 5:4 of option one are never looked at.
            opts_out.oc_timer_code <= img_reg[`HCID_IDX_OPT1][`HCID_O1_OC_TMR];
            opts_out.power_budget <= img_reg[`HCID_IDX_BUDGET];
            opts_out.controller_current_need <= img_reg[`HCID_IDX_CURRENT];
            opts_out.power_good_delay <= img_reg[`HCID_IDX_PGOOD];
            oc_limit_reg <= 20'(oc_steps(img_reg[`HCID_IDX_OPT1][`HCID_O1_OC_TMR]) * OC_STEP_CYC);
        end
    end

    //------------------------------------------------------------
    // Over-current filter
    //------------------------------------------------------------
    // Ganged sensing lets any port's sense pin count for every port.
    assign oc_sense = opts_out.oc_ganged ? {4{|(~ocs_sync_reg)}} : ~ocs_sync_reg;
    assign trip_any = |oc_trip_reg;

    generate
        for (genvar p = 0; p < 4; p++) begin : g_port
            // A glitch shorter than the limit restarts the count.
            always_ff @(posedge core_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    oc_cnt_reg[p] <= 20'h0;
                end else if (ce_in) begin
                    if (!cfg_valid_out || !oc_sense[p] || oc_trip_reg[p]) begin
                        oc_cnt_reg[p] <= 20'h0;
                    end else begin
                        oc_cnt_reg[p] <= oc_cnt_reg[p] + 20'h1;
                    end
                end
            end

            // The trip holds until power is dropped for the port; a new trip
            // in that cycle wins over the clear.
            always_ff @(posedge core_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    oc_trip_reg[p] <= 1'b0;
                end else if (ce_in) begin
                    if (cfg_valid_out && oc_sense[p] && oc_cnt_reg[p] == oc_limit_reg - 20'h1) begin
                        oc_trip_reg[p] <= 1'b1;
                    end else if (!port_power_req_in[p]) begin
                        oc_trip_reg[p] <= 1'b0;
                    end
                end
            end

            // Ganged switching drives every active port from the common request.
            assign port_on[p] = cfg_valid_out && !opts_out.port_inactive[p]
                && (opts_out.pwr_ganged ? (|port_power_req_in && !trip_any)
                : (port_power_req_in[p] && !oc_trip_reg[p]));
        end
    endgenerate

    // Switch and report outputs; switches stay off until the image is applied.
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            port_power_switch_n_out <= 4'hF;
            oc_report_out <= 4'h0;
        end else if (ce_in) begin
            port_power_switch_n_out <= ~port_on;
            oc_report_out <= oc_trip_reg;
        end
    end

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);

    power_gate_a: assert property (!cfg_valid_out |-> &port_power_switch_n_out)
        else $error("Port power on before image applied.");
    ident_order_a: assert property ($rose(cfg_valid_out) |->
        opts_out.vendor_code == {img_reg[0], img_reg[1]})
        else $error("Vendor code byte order wrong.");
    budget_byte_a: assert property ($rose(cfg_valid_out) |->
        opts_out.power_budget == img_reg[9] && opts_out.power_good_delay == img_reg[11])
        else $error("Power bytes not taken from bytes 9 and 11.");
    bus_mode_a: assert property ($rose(cfg_valid_out) |->
        opts_out.bus_powered == img_reg[6][7])
        else $error("Power mode not from option three bit 7.");
    speed_bit_a: assert property ($rose(cfg_valid_out) |->
        opts_out.full_speed_only == img_reg[6][5])
        else $error("Speed option not from option three bit 5.");
    inactive_off_a: assert property (ce_in && cfg_valid_out && opts_out.port_inactive[0]
        |=> port_power_switch_n_out[0])
        else $error("Inactive port powered.");
    strap_skip_a: assert property (slave_mode_reg |-> !ee_req_out)
        else $error("Memory read in slave mode.");
    oc_filter_a: assert property ($rose(oc_trip_reg[0]) |->
        $past(oc_cnt_reg[0]) == oc_limit_reg - 20'h1)
        else $error("Over-current tripped before filter time.");
    oc_cut_a: assert property ($rose(oc_report_out[0]) |-> port_power_switch_n_out[0])
        else $error("Over-current reported with power left on.");

    ee_load_c: cover property ($rose(cfg_valid_out) && !slave_mode_reg);
    slave_load_c: cover property ($rose(cfg_valid_out) && slave_mode_reg);
    oc_trip_c: cover property ($rose(oc_report_out[0]));
    ganged_c: cover property (cfg_valid_out && opts_out.pwr_ganged && trip_any);

endmodule

// *** tb/hcid_ee_model.sv ***
// Behavioural serial memory that answers image byte requests.
`timescale 1ns/1ps
module hcid_ee_model (
    // Clock.
    input wire logic clk_in,
    // Request side.
    input wire logic req_in,
    input wire logic [3:0] addr_in,
    // Answer side.
    output logic ack_out,
    output logic absent_out,
    output logic [7:0] data_out,
    // Contents and behaviour.
    input wire logic [95:0] image_in,
    input wire logic missing_in,
    input wire logic [3:0] delay_in
);
    int wait_cnt = 0;

    //------------------------------------------------------------
    // Handshake
    //------------------------------------------------------------
    // Outputs start idle, with the data line at an arbitrary level.
    initial begin
        ack_out = 1'b0;
        absent_out = 1'b0;
        data_out = 8'hA5;
    end

    // The answer comes delay_in cycles late. Between answers the data line flips
    // every cycle, so a reader that samples late never sees a stale byte.
    always @(posedge clk_in) begin
        #1;
        ack_out = 1'b0;
        absent_out = 1'b0;
        data_out = ~data_out;
        if (req_in && wait_cnt >= int'(delay_in)) begin
            wait_cnt = 0;
            absent_out = missing_in;
            ack_out = !missing_in;
            if (!missing_in) begin
                data_out = image_in[95 - 8 * int'(addr_in) -: 8];
            end
        end else if (req_in) begin
            wait_cnt++;
        end
    end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the hub configuration image decoder.
`timescale 1ns/1ps
module tb_top;
    import hcid_pkg::*;

    //------------------------------------------------------------
    // Stimulus and observed signals
    //------------------------------------------------------------
    // Active ports stay contiguous and reserved bits stay zero in both memory images.
    localparam logic [95:0] IMG_A = 96'h1234_5678_9ABC_A5_5C_8A_C8_96_10;
    localparam logic [95:0] IMG_B = 96'hA1B2_C3D4_E5F6_5A_A8_4F_32_64_32;
    localparam logic [95:0] IMG_S = 96'hFEDC_BA98_7654_43_0E_75_01_FF_7F;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic strap_n = 1'b1;
    logic slv_wr = 1'b0;
    logic slv_rd = 1'b0;
    logic slv_done = 1'b0;
    logic missing = 1'b0;
    logic ee_seen = 1'b0;
    logic [3:0] slv_addr = 4'h0;
    logic [3:0] req = 4'h0;
    logic [3:0] sense_n = 4'hF;
    logic [3:0] delay = 4'h0;
    logic [7:0] slv_wdata = 8'h00;
    logic [95:0] image = 96'h0;
    logic ee_req, ee_ack, ee_absent, cfg_valid;
    logic [3:0] ee_addr, sw_n, oc_rep;
    logic [7:0] ee_data, rdata;
    hcid_opts_s opts;
    int n_fail = 0;
    int num_checks = 0;

    // The clock toggles every half period of 10 ns, a 20 ns period.
    always #10 clk = ~clk;

    // Any memory request while the slave strap is chosen is remembered here.
    always @(posedge clk) ee_seen <= nrst ? (ee_seen | ee_req) : 1'b0;

    hcid_top #(.OC_STEP_CYC(8)) i_hcid_top (
        .core_clk_in(clk), .nrst_in(nrst), .ce_in(1'b1),
        .serial_slave_select_n_in(strap_n),
        .ee_req_out(ee_req), .ee_addr_out(ee_addr), .ee_ack_in(ee_ack),
        .ee_absent_in(ee_absent), .ee_data_in(ee_data),
        .slv_wr_in(slv_wr), .slv_rd_in(slv_rd), .slv_addr_in(slv_addr),
        .slv_wdata_in(slv_wdata), .slv_done_in(slv_done), .slv_rdata_out(rdata),
        .port_power_req_in(req), .overcurrent_sense_n_in(sense_n),
        .port_power_switch_n_out(sw_n), .oc_report_out(oc_rep),
        .cfg_valid_out(cfg_valid), .opts_out(opts)
    );

    hcid_ee_model i_hcid_ee_model (
        .clk_in(clk), .req_in(ee_req), .addr_in(ee_addr), .ack_out(ee_ack),
        .absent_out(ee_absent), .data_out(ee_data), .image_in(image),
        .missing_in(missing), .delay_in(delay)
    );

    //------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------
    // Every input change lands 1 ns after a rising edge, clear of the sampling edge.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // Drops the reserved bits of option byte one and packs fields in hcid_opts_s field order.
    function automatic logic [93:0] expect_opts(input logic [95:0] im);
        return {im[95:32], im[31:30], im[27:24], im[23:0]};
    endfunction

    task automatic do_reset(input logic strap);
        nrst = 1'b0;
        strap_n = strap;
        tick(5);
        nrst = 1'b1;
    endtask

    // Bounded wait, so a loader that never finishes shows as a mismatch.
    task automatic wait_cfg();
        int k = 0;
        while (cfg_valid !== 1'b1 && k < 400) begin
            tick(1);
            k++;
        end
        chk(cfg_valid, 1'b1);
    endtask

    task automatic slv_read(input logic [3:0] a, input logic [7:0] exp);
        slv_addr = a;
        slv_rd = 1'b1;
        tick(1);
        slv_rd = 1'b0;
        chk(rdata, exp);
        tick(1);
    endtask

    //------------------------------------------------------------
    // Scenarios
    //------------------------------------------------------------
    task automatic t_absent();
        missing = 1'b1;
        do_reset(1'b1);
        wait_cfg();
        chk(opts, 94'h0);
        missing = 1'b0;
    endtask

    task automatic t_ee_load(input logic [95:0] im, input logic [3:0] dly);
        image = im;
        delay = dly;
        do_reset(1'b1);
        chk(cfg_valid, 1'b0);
        wait_cfg();
        chk(opts, expect_opts(im));
    endtask

    // Ganged sensing, code A: 16 sensed cycles trip all active ports; 12 do not.
    task automatic t_overcurrent();
        req = 4'h7;
        tick(2);
        chk(sw_n, 4'hC);
        sense_n = 4'hD;
        tick(12);
        sense_n = 4'hF;
        tick(3);
        chk(oc_rep, 4'h0);
        sense_n = 4'hD;
        tick(24);
        chk({oc_rep[1:0], sw_n[1:0]}, 4'hF);
        sense_n = 4'hF;
        req = 4'h0;
        tick(4);
        chk({oc_rep, sw_n}, 8'h0F);
    endtask

    task automatic t_gang_switch();
        req = 4'h1;
        tick(2);
        chk(sw_n[2:0], 3'b000);
        req = 4'h0;
        tick(2);
    endtask

    // Back-to-back writes, reads in and out of range, then a refused late write.
    task automatic t_slave(input logic [95:0] im);
        do_reset(1'b0);
        tick(8);
        slv_wr = 1'b1;
        for (int i = 0; i < 12; i++) begin
            slv_addr = i[3:0];
            slv_wdata = im[95 - 8 * i -: 8];
            tick(1);
        end
        slv_wr = 1'b0;
        slv_read(4'h6, im[47:40]);
        slv_read(4'hC, 8'h00);
        slv_done = 1'b1;
        tick(1);
        slv_done = 1'b0;
        wait_cfg();
        chk(opts, expect_opts(im));
        slv_addr = 4'h6;
        slv_wdata = ~im[47:40];
        slv_wr = 1'b1;
        tick(1);
        slv_wr = 1'b0;
        tick(3);
        chk({opts, ee_seen}, {expect_opts(im), 1'b0});
    endtask

    //------------------------------------------------------------
    // Sequence, watchdog and verdict
    //------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // The whole run needs a few hundred cycles; 10000 means a hang.
    initial begin
        #200000;
        n_fail++;
        report_and_stop();
    end

    // The second and later resets arrive in mid-run on purpose.
    initial begin
        t_absent();
        t_ee_load(IMG_A, 4'h0);
        t_overcurrent();
        t_ee_load(IMG_B, 4'h5);
        t_gang_switch();
        t_slave(IMG_S);
        report_and_stop();
    end
endmodule
